// ### core/cache_controller.sv
// Cache directory controller between host bus and system-side bus
`timescale 1ns/1ps
module cache_controller
    import cache_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      rst_n,
    input  wire logic      strap_master,
    input  wire logic      strap_two_way,
    input  wire logic      host_ads,
    input  wire host_req_t host_req,
    output logic           host_ready,
    output logic           cache_rd_en,
    output logic           cache_wr_en,
    output logic           cache_way,
    output sys_out_t       sys_out,
    input  wire logic      sys_ready,
    input  wire logic      snoop_strobe,
    input  wire waddr_t    snoop_addr,
    input  wire logic      sysbus_hold_request_in,
    output logic           sysbus_hold_request_out,
    output logic           sysbus_hold_request_oe,
    input  wire logic      sysbus_hold_grant_in,
    output logic           sysbus_hold_grant_out,
    output logic           sysbus_hold_grant_oe
);
    ctl_t   st_r;
    ctl_t   st_nxt;
    logic   lk_hit;
    logic   lk_way;
    logic   lk_victim;
    logic   touch_en;
    logic   fill_en;
    logic   snoop_en;
    logic   snoop_hit;
    logic   own_bus;
    logic   may_start;
    logic   cacheable;
    waddr_t lk_addr;

    // Host lookup looks at the incoming strobe address
    assign lk_addr   = host_req.addr;
    assign cacheable = host_req.mio && !host_req.noncache;

    // Ownership of the system-side bus
    always_comb begin
        if (st_r.master) begin
            own_bus   = !st_r.grant;
            may_start = !st_r.grant && !sysbus_hold_request_in;
        end else begin
            own_bus   = st_r.hold_out && sysbus_hold_grant_in;
            may_start = own_bus;
        end
    end

    // Snoop only while another master holds the bus
    assign snoop_en = snoop_strobe && !own_bus;

    cache_directory u_dir (
        .clk        (clk),
        .rst_n      (rst_n),
        .assoc      (st_r.assoc),
        .lk_addr    (lk_addr),
        .lk_hit     (lk_hit),
        .lk_way     (lk_way),
        .lk_victim  (lk_victim),
        .touch_en   (touch_en),
        .fill_en    (fill_en),
        .fill_addr  (st_r.req.addr),
        .fill_way   (st_r.way),
        .snoop_en   (snoop_en),
        .snoop_addr (snoop_addr),
        .snoop_hit  (snoop_hit)
    );

    // Next-state logic for host side, system side and arbitration
    always_comb begin
        st_nxt          = st_r;
        st_nxt.ready    = 1'b0;
        st_nxt.cache_rd = 1'b0;
        st_nxt.cache_wr = 1'b0;
        st_nxt.sys.ads  = 1'b0;
        touch_en        = 1'b0;
        fill_en         = 1'b0;

        // Straps caught once in the first cycle after reset
        if (!st_r.taken) begin
            st_nxt.taken    = 1'b1;
            st_nxt.master   = strap_master;
            st_nxt.assoc    = strap_two_way;
            st_nxt.req_oe   = !strap_master;
            st_nxt.grant_oe = strap_master;
        end

        // Master mode grants only outside an active bus cycle
        st_nxt.grant = st_r.master && sysbus_hold_request_in
                       && st_r.state != S_SYS;

        case (st_r.state)
            S_IDLE: begin
                if (host_ads && st_r.taken) begin
                    st_nxt.req  = host_req;
                    st_nxt.fill = !host_req.write && cacheable;
                    if (!host_req.write && cacheable && lk_hit) begin
                        st_nxt.ready    = 1'b1;
                        st_nxt.cache_rd = 1'b1;
                        st_nxt.way      = lk_way;
                        touch_en        = 1'b1;
                    end else begin
                        st_nxt.state = S_WAIT_BUS;
                        st_nxt.way   = lk_victim;
                        if (host_req.write && cacheable && lk_hit) begin
                            st_nxt.cache_wr = 1'b1; // Write hit update
                            st_nxt.way      = lk_way;
                            touch_en        = 1'b1;
                        end
                    end
                end
            end
            S_WAIT_BUS: begin
                if (!st_r.master) begin
                    st_nxt.hold_out = 1'b1;
                end
                if (may_start) begin
                    st_nxt.state     = S_SYS;
                    st_nxt.sys.ads   = 1'b1;
                    st_nxt.sys.drive = 1'b1;
                    st_nxt.sys.addr  = st_r.req.addr;
                    st_nxt.sys.write = st_r.req.write;
                    st_nxt.sys.mio   = st_r.req.mio;
                    st_nxt.sys.be    = st_r.fill ? BE_ALL
                                                 : st_r.req.be;
                end
            end
            S_SYS: begin
                if (sys_ready) begin
                    st_nxt.state     = S_IDLE;
                    st_nxt.ready     = 1'b1;
                    st_nxt.sys.drive = 1'b0;
                    st_nxt.hold_out  = 1'b0;
                    if (st_r.fill) begin
                        fill_en         = 1'b1;
                        st_nxt.cache_wr = 1'b1;
                    end
                end
            end
            default: begin
                st_nxt.state = S_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= CTL_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from state flops
    assign host_ready              = st_r.ready;
    assign cache_rd_en             = st_r.cache_rd;
    assign cache_wr_en             = st_r.cache_wr;
    assign cache_way               = st_r.way;
    assign sys_out                 = st_r.sys;
    assign sysbus_hold_request_out = st_r.hold_out;
    assign sysbus_hold_request_oe  = st_r.req_oe;
    assign sysbus_hold_grant_out   = st_r.grant;
    assign sysbus_hold_grant_oe    = st_r.grant_oe;

    // Checks of the controller behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_HIT_NO_WAIT: assert property (
        st_r.state == S_IDLE && st_r.taken && host_ads && !host_req.write
        && cacheable && lk_hit |=> host_ready && cache_rd_en)
        else $error("read hit not answered next cycle");

    AST_MISS_OUT: assert property (
        st_r.state == S_IDLE && st_r.taken && host_ads && !lk_hit
        |=> st_r.state == S_WAIT_BUS && !host_ready)
        else $error("miss not forwarded");

    AST_START_BUS: assert property (
        st_r.state == S_WAIT_BUS && may_start |=> sys_out.ads
        && sys_out.addr == $past(st_r.req.addr))
        else $error("bus cycle not started when bus owned");

    AST_FULL_BE: assert property (
        sys_out.ads && !sys_out.write && st_r.fill |-> sys_out.be == BE_ALL)
        else $error("read miss without all byte enables");

    AST_NC_NO_FILL: assert property (
        fill_en |-> !st_r.req.noncache && st_r.req.mio && !st_r.req.write)
        else $error("non-cacheable or write access filled");

    AST_GRANT_AFTER: assert property (
        st_r.master && st_r.state == S_SYS && sys_ready
        && sysbus_hold_request_in ##1 sysbus_hold_request_in
        |=> sysbus_hold_grant_out && !sys_out.drive)
        else $error("hold not granted after cycle end");

    AST_NO_GRANT_MID: assert property (
        st_r.state == S_SYS |=> !sysbus_hold_grant_out || !sys_out.drive)
        else $error("grant given during own bus cycle");

    AST_SLAVE_DRIVE: assert property (
        !st_r.master && $rose(sys_out.drive) |->
            $past(sysbus_hold_grant_in) && $past(st_r.hold_out))
        else $error("slave drove bus without grant");

    AST_PIN_DIR: assert property (
        st_r.taken |-> sysbus_hold_request_oe != sysbus_hold_grant_oe
        && sysbus_hold_grant_oe == st_r.master)
        else $error("hold pair direction wrong");

    AST_SNOOP_OWNER: assert property (
        st_r.master && st_r.grant && snoop_strobe |-> snoop_en)
        else $error("snoop ignored while bus given away");

    // Host service and write-through while the bus is away
    AST_HIT_GRANTED: assert property (
        st_r.master && st_r.grant && st_r.state == S_IDLE && host_ads
        && !host_req.write && cacheable && lk_hit |=> host_ready)
        else $error("hit stalled while bus given away");

    AST_WRITE_OUT: assert property (
        st_r.state == S_IDLE && st_r.taken && host_ads && host_req.write
        |=> st_r.state == S_WAIT_BUS && !host_ready)
        else $error("write not sent to system bus");

    // Straps stay as caught after reset
    AST_STRAP_KEPT: assert property (
        st_r.taken |=> st_r.master == $past(st_r.master)
        && st_r.assoc == $past(st_r.assoc))
        else $error("strap mode changed after reset");

    // Master mode arbitration
    AST_GRANT_DROP: assert property (
        st_r.master && !sysbus_hold_request_in
        |=> !sysbus_hold_grant_out)
        else $error("grant kept without request");

    AST_NO_ADS_AWAY: assert property (
        st_r.master && (st_r.grant || sysbus_hold_request_in)
        |=> !sys_out.ads)
        else $error("bus cycle started while bus requested");

    // Slave mode request and release
    AST_SLAVE_ASK: assert property (
        !st_r.master && st_r.taken && st_r.state == S_WAIT_BUS
        |=> sysbus_hold_request_out)
        else $error("slave did not request the bus");

    AST_SLAVE_LET_GO: assert property (
        !st_r.master && st_r.state == S_SYS && sys_ready
        |=> !sysbus_hold_request_out && !sys_out.drive)
        else $error("slave kept bus after its cycle");

    // Direct mapped fills land in the pinned way
    AST_DM_FILL_WAY: assert property (
        fill_en && !st_r.assoc
        |-> st_r.way == st_r.req.addr[DM_WAY_BIT])
        else $error("direct mapped fill in wrong way");

    COV_HIT:   cover property (host_ads && lk_hit && cacheable
                               && !host_req.write ##1 host_ready);
    COV_FILL:  cover property (fill_en);
    COV_SNOOP: cover property (snoop_en && snoop_hit);
    COV_GRANT: cover property ($rose(sysbus_hold_grant_out));
    COV_HOLD_MID: cover property (st_r.master && st_r.state == S_SYS
                                  && sysbus_hold_request_in);

endmodule

// ### core/cache_pkg.sv
// Shared constants and carrier types of the cache directory controller
package cache_pkg;

    // Geometry: 4096 sets of two 32-bit lines hold 32 Kbyte
    localparam int          WADDR_W     = 30;
    localparam int          SET_W       = 12;
    localparam int          NUM_SETS    = 4096;
    localparam int          WAYS        = 2;
    localparam int          TAG_W       = 18;
    localparam int          TAG_LSB     = 12;
    localparam int          DM_WAY_BIT  = 12;
    localparam int          LINE_BYTES  = 4;
    localparam int          CACHE_BYTES = NUM_SETS * WAYS * LINE_BYTES;
    localparam logic [3:0]  BE_ALL      = 4'hF;

    // Word address: bit 0 is A2, bit 29 is A31
    typedef logic [WADDR_W-1:0] waddr_t;
    typedef logic [SET_W-1:0]   set_t;
    typedef logic [TAG_W-1:0]   tag_t;

    // Host request latched at address strobe
    typedef struct packed {
        logic       write;
        logic       mio;
        logic       noncache;
        logic [3:0] be;
        waddr_t     addr;
    } host_req_t;

    // System-side bus outputs, a processor-like front end
    typedef struct packed {
        logic       ads;
        logic       drive;
        logic       write;
        logic       mio;
        logic [3:0] be;
        waddr_t     addr;
    } sys_out_t;

    typedef enum logic [1:0] {S_IDLE, S_WAIT_BUS, S_SYS} ctl_state_t;

    // Whole state of the controller
    typedef struct packed {
        ctl_state_t state;
        host_req_t  req;
        sys_out_t   sys;
        logic       fill;
        logic       ready;
        logic       cache_rd;
        logic       cache_wr;
        logic       way;
        logic       grant;
        logic       hold_out;
        logic       master;
        logic       assoc;
        logic       taken;
        logic       req_oe;
        logic       grant_oe;
    } ctl_t;

    localparam ctl_t CTL_RESET = '0;

    function automatic set_t set_of(input waddr_t a);
        return a[SET_W-1:0];
    endfunction

    function automatic tag_t tag_of(input waddr_t a);
        return a[WADDR_W-1:TAG_LSB];
    endfunction

endpackage

// ### core/cache_directory.sv
// Tag directory with a host lookup port and a separate snoop port
`timescale 1ns/1ps
module cache_directory
    import cache_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   rst_n,
    input  wire logic   assoc,
    input  wire waddr_t lk_addr,
    output logic        lk_hit,
    output logic        lk_way,
    output logic        lk_victim,
    input  wire logic   touch_en,
    input  wire logic   fill_en,
    input  wire waddr_t fill_addr,
    input  wire logic   fill_way,
    input  wire logic   snoop_en,
    input  wire waddr_t snoop_addr,
    output logic        snoop_hit
);
    tag_t             tag_mem   [NUM_SETS][WAYS];
    logic [WAYS-1:0]  valid_mem [NUM_SETS];
    logic             lru_mem   [NUM_SETS];
    logic [WAYS-1:0]  lk_match;
    logic [WAYS-1:0]  sn_match;
    set_t             lk_set;
    set_t             sn_set;
    set_t             fl_set;

    assign lk_set = set_of(lk_addr);
    assign sn_set = set_of(snoop_addr);
    assign fl_set = set_of(fill_addr);

    // Per-way compare over the full tag; direct mode pins the way to A14
    for (genvar w = 0; w < WAYS; w++) begin : g_way
        assign lk_match[w] = valid_mem[lk_set][w]
            && tag_mem[lk_set][w] == tag_of(lk_addr)
            && (assoc || lk_addr[DM_WAY_BIT] == 1'(w));
        assign sn_match[w] = valid_mem[sn_set][w]
            && tag_mem[sn_set][w] == tag_of(snoop_addr)
            && (assoc || snoop_addr[DM_WAY_BIT] == 1'(w));
    end

    // Hit, hit way and replacement choice
    assign lk_hit    = |lk_match;
    assign lk_way    = lk_match[1];
    assign lk_victim = assoc ? lru_mem[lk_set] : lk_addr[DM_WAY_BIT];
    assign snoop_hit = |sn_match;

    // Valid bits and LRU; only fills validate, snoop hits clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_SETS; i++) begin
                valid_mem[i] <= '0;
                lru_mem[i]   <= 1'b0;
            end
        end else begin
            if (touch_en) begin
                lru_mem[lk_set] <= ~lk_way;
            end
            if (fill_en) begin
                valid_mem[fl_set][fill_way] <= 1'b1;
                lru_mem[fl_set]             <= ~fill_way;
            end
            // Per-way clear, so a fill of the other way survives
            if (snoop_en) begin
                for (int w = 0; w < WAYS; w++) begin
                    if (sn_match[w]) begin
                        valid_mem[sn_set][w] <= 1'b0;
                    end
                end
            end
        end
    end

    // Tag store, no reset needed behind valid bits
    always_ff @(posedge clk) begin
        if (fill_en) begin
            tag_mem[fl_set][fill_way] <= tag_of(fill_addr);
        end
    end

    AST_SNOOP_INVAL: assert property (@(posedge clk) disable iff (!rst_n)
        snoop_en && snoop_hit |=>
            (valid_mem[$past(sn_set)] & $past(sn_match)) == '0)
        else $error("snoop hit left entry valid");

    AST_FILL_VALID: assert property (@(posedge clk) disable iff (!rst_n)
        fill_en && !snoop_en |=>
            valid_mem[$past(fl_set)][$past(fill_way)])
        else $error("fill did not validate entry");

endmodule

// ### tb/sys_memory.sv
// System memory model answering system-side bus cycles
`timescale 1ns/1ps
module sys_memory
    import cache_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire sys_out_t   sys_out,
    input  wire logic [3:0] delay,
    output logic            sys_ready
);
    logic [3:0] cnt_r;
    logic       busy_r;

    // One ready pulse a chosen number of cycles after each strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 4'h0;
            busy_r <= 1'b0;
            sys_ready <= 1'b0;
        end else begin
            sys_ready <= 1'b0;
            if (sys_out.ads && sys_out.drive) begin
                busy_r <= 1'b1;
                cnt_r <= delay;
            end else if (busy_r && cnt_r == 4'h0) begin
                busy_r <= 1'b0;
                sys_ready <= 1'b1;
            end else if (busy_r) begin
                cnt_r <= cnt_r - 4'h1;
            end
        end
    end
endmodule

// ### tb/dual_bus_cache_controller_tb.sv
// Self-checking bench of the cache directory controller
`timescale 1ns/1ps
module dual_bus_cache_controller_tb;
    import cache_pkg::*;
    logic      clk, rst_n, strap_master, strap_two_way, host_ads;
    host_req_t host_req;
    logic      host_ready, cache_rd_en, cache_wr_en, cache_way;
    sys_out_t  sys_out;
    logic      sys_ready, snoop_strobe;
    waddr_t    snoop_addr;
    logic      req_in, req_out, req_oe, gnt_in, gnt_out, gnt_oe;
    logic      tb_req, tb_gnt, last_wr;
    logic [3:0] delay, last_be;
    waddr_t    last_addr;
    int        fails, tests_run, ads_cnt, cycles;
    localparam waddr_t A = 30'h0123_4567;

    // Pin levels from both parties' enables
    assign req_in = req_oe ? req_out : tb_req;
    assign gnt_in = gnt_oe ? gnt_out : tb_gnt;

    cache_controller i_dut (.clk(clk), .rst_n(rst_n),
        .strap_master(strap_master), .strap_two_way(strap_two_way),
        .host_ads(host_ads), .host_req(host_req), .host_ready(host_ready),
        .cache_rd_en(cache_rd_en), .cache_wr_en(cache_wr_en),
        .cache_way(cache_way), .sys_out(sys_out), .sys_ready(sys_ready),
        .snoop_strobe(snoop_strobe), .snoop_addr(snoop_addr),
        .sysbus_hold_request_in(req_in), .sysbus_hold_request_out(req_out),
        .sysbus_hold_request_oe(req_oe), .sysbus_hold_grant_in(gnt_in),
        .sysbus_hold_grant_out(gnt_out), .sysbus_hold_grant_oe(gnt_oe));

    sys_memory i_mem (.clk(clk), .rst_n(rst_n), .sys_out(sys_out),
        .delay(delay), .sys_ready(sys_ready));

    // Clock and cycle ceiling
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (sys_out.ads === 1'b1) begin
            ads_cnt++;
            last_be = sys_out.be;
            last_addr = sys_out.addr;
            last_wr = sys_out.write;
        end
        if (cycles == 6000) begin
            fails++;
            test_done();
        end
    end

    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic test_done();
        if (fails == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic do_reset(logic m, logic tw);
        rst_n = 1'b0;
        strap_master = m;
        strap_two_way = tw;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        check("request oe", {31'h0, !m}, {31'h0, req_oe});
        check("grant oe", {31'h0, m}, {31'h0, gnt_oe});
    endtask

    task automatic wait_ready(output int n);
        n = 0;
        do begin
            @(negedge clk);
            host_ads = 1'b0;
            n++;
        end while (host_ready !== 1'b1 && n < 60);
    endtask

    // One host access; hit means answer with no system cycle
    task automatic access(logic wr, logic nc, waddr_t a, logic hit);
        int n;
        int a0;
        @(negedge clk);
        a0 = ads_cnt;
        host_req = '{write: wr, mio: 1'b1, noncache: nc, be: 4'h3, addr: a};
        host_ads = 1'b1;
        wait_ready(n);
        if (hit) begin
            check("hit latency", 1, n);
            check("hit read", 1, {31'h0, cache_rd_en});
            check("hit sys cycles", a0, ads_cnt);
        end else begin
            check("miss sys cycles", a0 + 1, ads_cnt);
            check("miss ready", 1, {31'h0, host_ready});
            check("miss be", (wr || nc) ? 4'h3 : BE_ALL,
                  {28'h0, last_be});
            check("miss addr", {2'h0, a}, {2'h0, last_addr});
            check("miss write", {31'h0, wr}, {31'h0, last_wr});
            check("fill", {31'h0, !wr && !nc}, {31'h0, cache_wr_en});
        end
    endtask

    task automatic t_basic();
        do_reset(1'b1, 1'b0);
        access(1'b0, 1'b0, A, 1'b0);
        access(1'b0, 1'b0, A, 1'b1);
        access(1'b0, 1'b0, A ^ 30'h0000_1000, 1'b0);
        access(1'b0, 1'b0, A, 1'b1);
        access(1'b0, 1'b1, A + 30'h1, 1'b0);
        access(1'b0, 1'b1, A + 30'h1, 1'b0);
        access(1'b1, 1'b0, A + 30'h2, 1'b0);
        access(1'b0, 1'b0, A + 30'h2, 1'b0);
        access(1'b0, 1'b0, A ^ 30'h2000_0000, 1'b0);
    endtask

    task automatic t_snoop();
        do_reset(1'b1, 1'b1);
        delay = 4'h5;
        access(1'b0, 1'b0, A, 1'b0);
        access(1'b0, 1'b0, A + 30'h1, 1'b0);
        tb_req = 1'b1;
        repeat (2) @(negedge clk);
        check("grant", 1, {31'h0, gnt_out});
        access(1'b0, 1'b0, A + 30'h1, 1'b1);
        @(negedge clk);
        host_req = '{write: 1'b0, mio: 1'b1, noncache: 1'b0, be: 4'h3,
                     addr: A + 30'h1};
        host_ads = 1'b1;
        snoop_addr = A;
        snoop_strobe = 1'b1;
        @(negedge clk);
        host_ads = 1'b0;
        snoop_strobe = 1'b0;
        check("hit beside snoop", 1, {31'h0, host_ready});
        tb_req = 1'b0;
        repeat (2) @(negedge clk);
        check("grant drop", 0, {31'h0, gnt_out});
        access(1'b0, 1'b0, A, 1'b0);
        access(1'b0, 1'b0, A + 30'h1, 1'b1);
        snoop_addr = A + 30'h1;
        snoop_strobe = 1'b1;
        @(negedge clk);
        snoop_strobe = 1'b0;
        access(1'b0, 1'b0, A + 30'h1, 1'b1);
        delay = 4'h0;
    endtask

    // Hold request during an own cycle waits for its end
    task automatic t_hold_mid();
        int n;
        do_reset(1'b1, 1'b0);
        delay = 4'h5;
        host_req = '{write: 1'b0, mio: 1'b1, noncache: 1'b1, be: 4'h3,
                     addr: A};
        host_ads = 1'b1;
        @(negedge clk);
        host_ads = 1'b0;
        @(negedge clk);
        tb_req = 1'b1;
        @(negedge clk);
        check("grant in cycle", 0, {31'h0, gnt_out});
        wait_ready(n);
        check("nc ready", 1, {31'h0, host_ready});
        check("grant at end", 0, {31'h0, gnt_out});
        @(negedge clk);
        check("grant after end", 1, {31'h0, gnt_out});
        check("released", 0, {31'h0, sys_out.drive});
        tb_req = 1'b0;
        repeat (2) @(negedge clk);
        delay = 4'h0;
    endtask

    // Same set, same way bit, other tag: kept only when two-way
    task automatic t_assoc();
        for (int tw = 0; tw < 2; tw++) begin
            do_reset(1'b1, tw[0]);
            access(1'b0, 1'b0, A, 1'b0);
            access(1'b0, 1'b0, A ^ 30'h0010_0000, 1'b0);
            access(1'b0, 1'b0, A, tw[0]);
            access(1'b0, 1'b0, A ^ 30'h0010_0000, tw[0]);
            check("way", {31'h0, tw[0]}, {31'h0, cache_way});
        end
    endtask

    task automatic t_slave();
        int n;
        int a0;
        do_reset(1'b0, 1'b0);
        a0 = ads_cnt;
        host_req = '{write: 1'b0, mio: 1'b1, noncache: 1'b0, be: 4'hF, addr: A};
        host_ads = 1'b1;
        @(negedge clk);
        host_ads = 1'b0;
        repeat (5) @(negedge clk);
        check("slave request", 1, {31'h0, req_out});
        check("slave no cycle", a0, ads_cnt);
        check("slave no drive", 0, {31'h0, sys_out.drive});
        tb_gnt = 1'b1;
        wait_ready(n);
        check("slave cycle", a0 + 1, ads_cnt);
        check("slave ready", 1, {31'h0, host_ready});
        tb_gnt = 1'b0;
        access(1'b0, 1'b0, A, 1'b1);
    endtask

    // Main sequence
    initial begin
        rst_n = 1'b0;
        strap_master = 1'b1;
        strap_two_way = 1'b0;
        host_ads = 1'b0;
        host_req = '0;
        snoop_strobe = 1'b0;
        snoop_addr = '0;
        tb_req = 1'b0;
        tb_gnt = 1'b0;
        delay = 4'h0;
        fails = 0;
        tests_run = 0;
        ads_cnt = 0;
        cycles = 0;
        t_basic();
        t_snoop();
        t_hold_mid();
        t_assoc();
        t_slave();
        test_done();
    end
endmodule
